// ---- logic/emitter_pulse_pkg.sv ----
// Constants and types for the emitter pulse configuration block.
// Assumes a single 200 MHz clock; timing counts are derived here.
package emitter_pulse_pkg;

  // Clock period and base time units, each in its own unit
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned BASE_SHORT_NS = 25000;
  localparam int unsigned BASE_LONG_NS = 50000;
  // Cycle counts of one base unit (exact at 200 MHz)
  localparam int unsigned BASE_SHORT_CYC =
    (BASE_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BASE_LONG_CYC =
    (BASE_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int UNIT_CNT_W = 16;

  // Command code reaching both configuration bytes
  localparam logic [7:0] CMD_EMITTER_CONFIG = 8'h01;

  // Field positions, low byte
  localparam int WIDTH_LSB = 4;
  localparam int COUNT_LSB = 2;
  localparam int BASE_SEL_BIT = 1;
  // Field position, high byte (bits 10:8 of the word)
  localparam int DRIVE_LSB = 0;

  // Reset values of both bytes
  localparam logic [7:0] TIMING_LOW_RST = 8'h00;
  localparam logic [7:0] CURRENT_HIGH_RST = 8'h00;

  // Drive current in milliamperes for each three-bit code
  localparam logic [4:0] DRIVE_MA [8] = '{
    5'h07, 5'h09, 5'h0B, 5'h0C, 5'h0F, 5'h11, 5'h13, 5'h14
  };

  // Decoded fields of one measurement
  typedef struct packed {
    logic [2:0] emitter_drive_level;
    logic [1:0] pulse_width_multiple;
    logic [1:0] pulses_per_measurement;
    logic base_time_unit_select;
  } emitter_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PULSE = 3'b010,
    ST_GAP = 3'b100
  } pulse_state_e;

endpackage

// ---- logic/emitter_pulse_config.sv ----
// Emitter pulse configuration registers and pulse timing generator.
// Assumes command-coded byte access from a bus front end on mclk,
// and power-on and measurement start from logic on the same clock.
//
// Overview of operation
// - Width code 00..11 gives 1,2,4,8 units
// - Base-unit bit selects 25 or 50 us
// - Count code 00..11 gives 1,2,4,8 pulses
// - Drive code selects 7 to 20 mA
// - Pulse width is multiple times base unit
// - Timing fields low byte, current high, command 01
// - Pulses only while on and measuring
`timescale 1ns/1ps
module emitter_pulse_config
  import emitter_pulse_pkg::*;
#(
  parameter int unsigned SHORT_UNIT_CYC = BASE_SHORT_CYC,
  parameter int unsigned LONG_UNIT_CYC = BASE_LONG_CYC
) (
  input wire logic mclk, // 200 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  input wire logic [7:0] reg_cmd, // Command code
  input wire logic [15:0] reg_wdata, // High byte, low byte
  output logic [15:0] reg_rdata, // Read data, registered
  input wire logic sensor_power_on, // Sensor switched on
  input wire logic meas_start, // Start measurement phase
  output logic emitter_on, // Emitter pulse active
  output logic [2:0] emitter_drive_code, // Current code of pulse
  output logic [4:0] emitter_current_ma, // Current in mA
  output logic meas_busy, // Measurement phase active
  output logic meas_done // Pulses complete, one cycle
);

  logic [7:0] emitter_timing_config_low;
  logic [7:0] emitter_current_config_high;
  emitter_cfg_s live_cfg;
  emitter_cfg_s meas_cfg;
  pulse_state_e state;
  logic [UNIT_CNT_W-1:0] unit_cnt;
  logic [UNIT_CNT_W-1:0] unit_len;
  logic [3:0] units_left;
  logic [3:0] pulses_left;
  logic unit_end;

  // Field decode from both bytes
  assign live_cfg.pulse_width_multiple =
    emitter_timing_config_low[WIDTH_LSB +: 2];
  assign live_cfg.pulses_per_measurement =
    emitter_timing_config_low[COUNT_LSB +: 2];
  assign live_cfg.base_time_unit_select =
    emitter_timing_config_low[BASE_SEL_BIT];
  assign live_cfg.emitter_drive_level =
    emitter_current_config_high[DRIVE_LSB +: 3];

  // Both bytes written together under the one command code
  always_ff @(posedge mclk) begin
    if (rst) begin
      emitter_timing_config_low <= TIMING_LOW_RST;
      emitter_current_config_high <= CURRENT_HIGH_RST;
    end else if (reg_wr && reg_cmd == CMD_EMITTER_CONFIG) begin
      emitter_timing_config_low <= reg_wdata[7:0];
      emitter_current_config_high <= reg_wdata[15:8];
    end
  end

  // Readback; unknown commands read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_cmd == CMD_EMITTER_CONFIG) begin
        reg_rdata <= {emitter_current_config_high,
                      emitter_timing_config_low};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // Base unit length from the snapshot taken at measurement start
  assign unit_len = meas_cfg.base_time_unit_select ?
    UNIT_CNT_W'(LONG_UNIT_CYC) : UNIT_CNT_W'(SHORT_UNIT_CYC);
  assign unit_end = (unit_cnt == unit_len - UNIT_CNT_W'(1));

  // Snapshot config so a write mid-measurement cannot tear a pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      meas_cfg <= '0;
    end else if (state == ST_IDLE && meas_start && sensor_power_on) begin
      meas_cfg <= live_cfg;
    end
  end

  // Pulse sequencer; power off aborts at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
      emitter_on <= 1'b0;
      meas_busy <= 1'b0;
      meas_done <= 1'b0;
      unit_cnt <= '0;
      units_left <= 4'h0;
      pulses_left <= 4'h0;
    end else begin
      meas_done <= 1'b0;
      if (!sensor_power_on) begin
        state <= ST_IDLE;
        emitter_on <= 1'b0;
        meas_busy <= 1'b0;
        unit_cnt <= '0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (meas_start) begin
              state <= ST_PULSE;
              emitter_on <= 1'b1;
              meas_busy <= 1'b1;
              unit_cnt <= '0;
              units_left <= 4'h1 << live_cfg.pulse_width_multiple;
              pulses_left <=
                4'h1 << live_cfg.pulses_per_measurement;
            end
          end
          ST_PULSE: begin
            if (unit_end) begin
              unit_cnt <= '0;
              units_left <= units_left - 4'h1;
              if (units_left == 4'h1) begin
                emitter_on <= 1'b0;
                pulses_left <= pulses_left - 4'h1;
                if (pulses_left == 4'h1) begin
                  state <= ST_IDLE;
                  meas_busy <= 1'b0;
                  meas_done <= 1'b1;
                end else begin
                  state <= ST_GAP;
                end
              end
            end else begin
              unit_cnt <= unit_cnt + UNIT_CNT_W'(1);
            end
          end
          ST_GAP: begin
            // One dead cycle keeps pulses distinct without overlap
            state <= ST_PULSE;
            emitter_on <= 1'b1;
            units_left <= 4'h1 << meas_cfg.pulse_width_multiple;
          end
          default: begin
            state <= ST_IDLE;
            emitter_on <= 1'b0;
            meas_busy <= 1'b0;
          end
        endcase
      end
    end
  end

  // Amplitude follows the snapshot drive code; held when dark
  always_ff @(posedge mclk) begin
    if (rst) begin
      emitter_drive_code <= 3'h0;
      emitter_current_ma <= 5'h00;
    end else begin
      emitter_drive_code <= meas_cfg.emitter_drive_level;
      emitter_current_ma <=
        DRIVE_MA[meas_cfg.emitter_drive_level];
    end
  end

  // Helper counters seen only by the checks below
  logic [31:0] on_len;
  logic [31:0] on_total;
  logic [3:0] pulse_edges;
  logic on_d;
  always_ff @(posedge mclk) begin
    if (rst) begin
      on_len <= 32'h0;
      on_total <= 32'h0;
      pulse_edges <= 4'h0;
      on_d <= 1'b0;
    end else begin
      on_d <= emitter_on;
      on_len <= emitter_on ? on_len + 32'h1 : 32'h0;
      if (meas_start && state == ST_IDLE) begin
        on_total <= 32'h0;
        pulse_edges <= 4'h0;
      end else begin
        on_total <= on_total + {31'h0, emitter_on};
        pulse_edges <= pulse_edges + {3'h0, emitter_on && !on_d};
      end
    end
  end

  // Covers both the start path and the path through the dark gap
  chk_width_units: assert property (@(posedge mclk) disable iff (rst)
    $rose(emitter_on) |-> units_left ==
      (4'h1 << meas_cfg.pulse_width_multiple))
    else $error("pulse width units wrong");
  chk_base_unit: assert property (@(posedge mclk) disable iff (rst)
    state == ST_PULSE |-> unit_cnt < (meas_cfg.base_time_unit_select ?
      UNIT_CNT_W'(LONG_UNIT_CYC) : UNIT_CNT_W'(SHORT_UNIT_CYC)))
    else $error("base unit length wrong");
  chk_pulse_count: assert property (@(posedge mclk) disable iff (rst)
    meas_done |-> pulse_edges == (4'h1 << meas_cfg.pulses_per_measurement))
    else $error("pulse count wrong");
  chk_drive_level: assert property (@(posedge mclk) disable iff (rst)
    emitter_on && $stable(meas_cfg) |=>
      emitter_current_ma == DRIVE_MA[$past(meas_cfg.emitter_drive_level)])
    else $error("drive current wrong");
  chk_pulse_width: assert property (@(posedge mclk) disable iff (rst)
    $fell(emitter_on) && meas_busy |-> $past(on_len) ==
      32'(unit_len) * (32'h1 << meas_cfg.pulse_width_multiple) - 32'h1)
    else $error("pulse width wrong");
  chk_cfg_write: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_cmd == CMD_EMITTER_CONFIG |=>
      {emitter_current_config_high, emitter_timing_config_low}
        == $past(reg_wdata))
    else $error("config write lost");
  chk_only_on: assert property (@(posedge mclk) disable iff (rst)
    emitter_on |-> $past(sensor_power_on) && meas_busy)
    else $error("emitter lit while off");
  chk_total_on: assert property (@(posedge mclk) disable iff (rst)
    meas_done |-> on_total == 32'(unit_len) *
      (32'h1 << meas_cfg.pulse_width_multiple) *
      (32'h1 << meas_cfg.pulses_per_measurement))
    else $error("total on-time wrong");

endmodule

// ---- verif/config_host.sv ----
// Host model that programs the emitter configuration word.
// Assumes the bench calls its tasks; it drives 1 ns after mclk rises.
`timescale 1ns/1ps
module config_host (
  input wire logic mclk, // Shared clock
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [7:0] reg_cmd, // Command code
  output logic [15:0] reg_wdata, // Word to write
  input wire logic [15:0] reg_rdata // Word read back
);
  // Quiet bus before the first access
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
  end
  // One-cycle write; lines invert after so stale data never looks valid
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge mclk);
    #1;
    reg_wr = 1'b1;
    reg_cmd = cmd;
    reg_wdata = data;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_cmd = ~cmd;
    reg_wdata = ~data;
  endtask
  // One-cycle read; word is registered by the edge that takes it
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
    @(posedge mclk);
    #1;
    reg_rd = 1'b1;
    reg_cmd = cmd;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    reg_cmd = ~cmd;
    data = reg_rdata;
  endtask
  // Long range: width, then current, then 50 us base, count left at one
  task automatic long_range;
    wr(8'h01, 16'h0030);
    wr(8'h01, 16'h0730);
    wr(8'h01, 16'h0732);
  endtask
endmodule

// ---- verif/emitter_pulse_config_bench.sv ----
// Self-checking bench for the emitter pulse configuration block.
// Assumes short base units of 2 and 4 cycles to keep pulses brief.
`timescale 1ns/1ps
module emitter_pulse_config_bench;
  localparam int unsigned SU = 2;
  localparam int unsigned LU = 4;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sensor_power_on = 1'b0;
  logic meas_start = 1'b0;
  logic reg_wr, reg_rd, emitter_on, meas_busy, meas_done;
  logic [7:0] reg_cmd;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] emitter_drive_code;
  logic [4:0] emitter_current_ma;
  logic [4:0] ma [8] = '{5'h07, 5'h09, 5'h0B, 5'h0C, 5'h0F, 5'h11, 5'h13,
    5'h14};
  int num_errors = 0;
  int n_checks = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  config_host u_config_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  emitter_pulse_config #(.SHORT_UNIT_CYC(SU), .LONG_UNIT_CYC(LU))
    u_emitter_pulse_config (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sensor_power_on(sensor_power_on),
    .meas_start(meas_start), .emitter_on(emitter_on),
    .emitter_drive_code(emitter_drive_code),
    .emitter_current_ma(emitter_current_ma), .meas_busy(meas_busy),
    .meas_done(meas_done));
  task automatic bad(input string msg);
    $display("BAD %0t %s", $time, msg);
    num_errors++;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset word, readback, and a write under an unmapped code
  task automatic t_regs;
    logic [15:0] d;
    u_config_host.rd(8'h01, d);
    n_checks++;
    if (d !== 16'h0000) bad("reset word");
    u_config_host.wr(8'h01, 16'hA5C3);
    u_config_host.wr(8'h02, 16'h0000);
    u_config_host.rd(8'h01, d);
    n_checks++;
    if (d !== 16'hA5C3) bad("readback");
    u_config_host.rd(8'h02, d);
    n_checks++;
    if (d !== 16'h0000) bad("unmapped read");
  endtask
  // One measurement: width, count, on-time and length are all measured
  task automatic t_meas(input int w, input int n, input int b, input int dr);
    int u, on, run, mx, pulses, k;
    logic prev, done;
    u = b ? LU : SU;
    on = 0;
    run = 0;
    mx = 0;
    pulses = 0;
    k = 0;
    prev = 1'b0;
    done = 1'b0;
    @(posedge mclk);
    #1;
    meas_start = 1'b1;
    @(posedge mclk);
    #1;
    meas_start = 1'b0;
    while (done == 1'b0 && k < 2000) begin
      k++;
      // Drive outputs lag the snapshot by a cycle, so look mid-pulse
      if (k == 2) begin
        n_checks += 3;
        if (emitter_current_ma !== ma[dr]) bad("drive mA");
        if (emitter_drive_code !== dr[2:0]) bad("drive code");
        if (emitter_on !== 1'b1 || meas_busy !== 1'b1) bad("not lit");
      end
      if (emitter_on === 1'b1) begin
        on++;
        run++;
        if (prev == 1'b0) pulses++;
      end else run = 0;
      if (run > mx) mx = run;
      prev = emitter_on;
      if (meas_done === 1'b1) done = 1'b1;
      else begin
        @(posedge mclk);
        #1;
      end
    end
    if (done == 1'b0) begin
      bad("no done");
      wrap_up();
    end else begin
      n_checks += 5;
      if (mx != (u << w)) bad("pulse width");
      if (pulses != (1 << n)) bad("pulse count");
      if (on != ((u << w) << n)) bad("on time");
      if (k != (1 << n) * ((u << w) + 1)) bad("length");
      if (meas_busy !== 1'b0) bad("busy after done");
    end
  endtask
  // Start refused while off; power loss aborts without done
  task automatic t_power;
    sensor_power_on = 1'b0;
    meas_start = 1'b1;
    @(posedge mclk);
    #1;
    meas_start = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    n_checks++;
    if (emitter_on !== 1'b0 || meas_busy !== 1'b0) bad("lit off");
    sensor_power_on = 1'b1;
    meas_start = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    meas_start = 1'b0;
    sensor_power_on = 1'b0;
    @(posedge mclk);
    #1;
    n_checks++;
    if (emitter_on !== 1'b0 || meas_busy !== 1'b0) bad("no abort");
    repeat (40) begin
      @(posedge mclk);
      #1;
      if (meas_done !== 1'b0 || emitter_on !== 1'b0) bad("after abort");
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    sensor_power_on = 1'b1;
    t_regs();
    // Every width, count, base and drive code at least once
    for (int i = 0; i < 8; i++) begin
      u_config_host.wr(8'h01, {5'h00, i[2:0], 2'b00, i[1:0], i[2:1], i[0],
        1'b0});
      t_meas(i % 4, i >> 1, i % 2, i);
    end
    u_config_host.long_range();
    t_meas(3, 0, 1, 7);
    t_power();
    wrap_up();
  end
endmodule
